// File: host_model.sv
/*
  Host controller model: drives the four control inputs and enable.
  Assumes callers hold every level for at least one internal cycle.
*/
`timescale 1ns/100ps
module host_model
(
  input  wire logic                                    ref_clk,
  output logic      [led_phase_fault_pkg::NUM_CTRL-1:0] pwm_control_input,
  output logic                                         enable
);
  import led_phase_fault_pkg::*;
  initial
  begin
    pwm_control_input = 4'h0;
    enable            = 1'b0;
  end
  // levels move just after the edge; shorter pulses may be lost
  task automatic drive(input logic [NUM_CTRL-1:0] c, input logic e);
    @(posedge ref_clk);
    pwm_control_input <= c;
    enable            <= e;
  endtask : drive
  // low phase of two internal cycles so the clear is always seen
  task automatic toggle_enable();
    drive(pwm_control_input, 1'b0);
    repeat (256) @(posedge ref_clk);
    drive(pwm_control_input, 1'b1);
  endtask : toggle_enable
endmodule : host_model

// File: led_channel_phase_fault_ctrl.sv
/*
  Gate sequencing and fault supervision for eight external LED string
  transistors: staggered turn-on from four control inputs, comparator
  qualification, fault latching and a duty-coded open-drain indicator.
  Assumes all pin inputs are asynchronous and reset is the power-on reset.
*/
// Notes on behaviour
// RULE1: unit stagger delay is four internal clock cycles, about 13 us.
// RULE2: first control rise turns channel 1 on at once, channel 2 one unit later.
// RULE3: second control turns channel 3 on after two units, channel 4 after three.
// RULE4: third control turns channels 5 and 6 on after four and five units.
// RULE5: fourth control turns channels 7 and 8 on after six and seven units.
// RULE6: four-group mode: first control drives channels 1,2,6,7 at 0,1,5,6 units; the code also drives channel 5 from it.
// RULE7: four-group mode: third control drives channels 3,4,7,8 at 2,3,6,7 units.
// RULE8: stagger applies identically in every grouping mode, eight-group included.
// RULE9: shortest gate pulse is one internal cycle; host keeps pulses at least that long.
// RULE10: faulty channel switches off first, indicator starts afterwards.
// RULE11: indicator toggles at about 80 kHz while reporting.
// RULE12: indicator low duty 25/50/75/100 percent by fault type.
// RULE13: open, short and transistor-open checked only while on; confirmed ones latch.
// RULE14: string-short threshold fixed in two-group mode, pin-set otherwise.
// RULE15: transistor short is continuous, unlatched, with 0.9 V set and 0.7 V release.
// RULE16: overtemperature latches, turns off regulator and all channels, indicator fully low.
// RULE17: after turn-on wait a settle time before sampling comparators.
// RULE18: abnormality confirmed after qualify time, then channel off and notification.
// RULE19: latched errors clear on enable high-low-high or power-on reset.
// RULE20: settle and qualify times are each 13 us; the code rounds each up to five internal cycles, 16 us.
// RULE21: enable high lets controls drive channels; enable low forces all off.
// RULE22: enable change acts on all channels at once, no stagger.
// RULE23: delays and timers are counters of the internal clock.
`timescale 1ns/100ps

module led_channel_phase_fault_ctrl
(
  input  wire logic                                    ref_clk,
  input  wire logic                                    reset,
  input  wire logic [led_phase_fault_pkg::NUM_CTRL-1:0] pwm_control_input,
  input  wire logic                                    enable,
  input  wire logic [1:0]                              feedback_mode,
  input  wire logic [led_phase_fault_pkg::NUM_CH-1:0]   drain_open_cmp,
  input  wire logic [led_phase_fault_pkg::NUM_CH-1:0]   drain_short_cmp,
  input  wire logic [led_phase_fault_pkg::NUM_CH-1:0]   source_open_cmp,
  input  wire logic [led_phase_fault_pkg::NUM_CH-1:0]   source_above_set,
  input  wire logic [led_phase_fault_pkg::NUM_CH-1:0]   source_below_release,
  input  wire logic                                    overtemp_detect,
  output logic      [led_phase_fault_pkg::NUM_CH-1:0]   gate_drive_output,
  output logic                                         short_ref_from_pin,
  output logic                                         regulator_output_enable,
  output logic      [led_phase_fault_pkg::NUM_CH-1:0]   channel_fault_latched,
  output logic                                         fault_indicator_output,
  output logic                                         fault_indicator_oe
);
  import led_phase_fault_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // which control inputs drive a channel in a given grouping mode
  function automatic logic [NUM_CTRL-1:0] ctrl_mask(input logic [1:0] mode, input int ch);
    logic [NUM_CTRL-1:0] m;
    m = '0;
    case (mode)
      MODE_FOUR:
      begin
        case (ch)
          0, 1, 4, 5: m = 4'h1;                                 // RULE6
          6:          m = 4'h5;                                 // RULE6 RULE7
          default:    m = 4'h4;                                 // RULE7
        endcase
      end
      MODE_EIGHT: m = 4'h1;                                     // RULE8
      default:    m = NUM_CTRL'(4'h1 << (ch / 2));              // RULE2 RULE3 RULE4 RULE5
    endcase
    return m;
  endfunction : ctrl_mask

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: first stage feeds only the second
  localparam int SYN_W = NUM_CTRL + 4 + 5 * NUM_CH;
  logic [SYN_W-1:0] sync_a;
  logic [SYN_W-1:0] sync_b;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {pwm_control_input, enable, feedback_mode, overtemp_detect, drain_open_cmp,
                 drain_short_cmp, source_open_cmp, source_above_set, source_below_release};
      sync_b <= sync_a;
    end
  end

  logic [NUM_CTRL-1:0] ctrl_s;
  logic                en_s;
  logic [1:0]          mode_s;
  logic                ot_s;
  logic [NUM_CH-1:0]   d_open_s;
  logic [NUM_CH-1:0]   d_short_s;
  logic [NUM_CH-1:0]   s_open_s;
  logic [NUM_CH-1:0]   s_high_s;
  logic [NUM_CH-1:0]   s_low_s;

  assign {ctrl_s, en_s, mode_s, ot_s, d_open_s, d_short_s, s_open_s, s_high_s, s_low_s} = sync_b;

  //////////////////////////////////////////////////////////////////////////////
  // internal clock: one-cycle tick every INT_DIV reference cycles
  logic [DIV_W-1:0] div_cnt;
  logic             tick;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      div_cnt <= '0;
    else if (div_cnt == DIV_W'(INT_DIV - 1))
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  assign tick = (div_cnt == DIV_W'(INT_DIV - 1));                // RULE23

  //////////////////////////////////////////////////////////////////////////////
  // control history, one entry per internal tick; sampling at tick rate is
  // what makes one internal cycle the shortest pulse that survives
  logic [NUM_CTRL-1:0] hist [HIST_LEN];

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hist <= '{default: '0};
    else if (tick)                                              // RULE9 RULE23
    begin
      hist[0] <= ctrl_s;
      for (int i = 1; i < HIST_LEN; i++)
        hist[i] <= hist[i-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable edge tracking and latched-error release
  logic en_prev;
  logic en_rise;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      en_prev <= 1'b0;
    else
      en_prev <= en_s;
  end

  assign en_rise = en_s & ~en_prev;                              // RULE19

  // overtemperature: latched, released like channel faults
  logic ot_latched;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ot_latched <= 1'b0;
    else
      ot_latched <= ot_s | (ot_latched & ~en_rise);               // RULE16 RULE19
  end

  assign regulator_output_enable = ~ot_latched;                 // RULE16
  assign short_ref_from_pin      = (mode_s != MODE_TWO);        // RULE14

  //////////////////////////////////////////////////////////////////////////////
  // per-channel sequencing and fault qualification
  logic [NUM_CH-1:0] kind_open;
  logic [NUM_CH-1:0] kind_short;
  logic [NUM_CH-1:0] kind_tr_open;
  logic [NUM_CH-1:0] tr_short;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [NUM_CTRL-1:0] tap;
    logic                req;
    logic                next_gate;
    logic [TMR_W-1:0]    settle_cnt;
    logic [TMR_W-1:0]    qual_cnt;
    logic                settled;
    logic                abnormal;
    fault_kind_t         seen;
    logic [2:0]          latched;

    // channel k turns on k unit delays after its control input
    if (ch == 0)
    begin : g_now
      assign tap = ctrl_s;                                      // RULE2
    end
    else
    begin : g_late
      assign tap = hist[ch * UNIT_TICKS];                       // RULE1 RULE3 RULE4 RULE5
    end

    assign req = |(ctrl_mask(mode_s, ch) & tap);
    // enable and shutdown act directly, outside the stagger
    assign next_gate = en_s & req & ~(|latched) & ~ot_latched;  // RULE21 RULE22 RULE10 RULE16

    always_ff @(posedge ref_clk)
    begin
      if (reset)
        gate_drive_output[ch] <= 1'b0;
      else
        gate_drive_output[ch] <= next_gate;
    end

    // settle timer runs in internal ticks while the gate is on
    always_ff @(posedge ref_clk)
    begin
      if (reset || !gate_drive_output[ch])
        settle_cnt <= '0;
      else if (tick && !settled)
        settle_cnt <= settle_cnt + 1'b1;                        // RULE17 RULE20
    end

    assign settled  = (settle_cnt == TMR_W'(SETTLE_TICKS));
    assign abnormal = gate_drive_output[ch] & settled &
                      (d_open_s[ch] | d_short_s[ch] | s_open_s[ch]);  // RULE13

    // short threshold selection is analog; drain_short_cmp already reflects it
    always_ff @(posedge ref_clk)
    begin
      if (reset || !abnormal)
        qual_cnt <= '0;
      else if (tick && qual_cnt != TMR_W'(QUALIFY_TICKS))
        qual_cnt <= qual_cnt + 1'b1;                            // RULE18 RULE20
    end

    always_comb
    begin
      if (d_open_s[ch])
        seen = KIND_STR_OPEN;
      else if (d_short_s[ch])
        seen = KIND_STR_SHORT;
      else
        seen = KIND_TR_OPEN;
    end

    // a confirm in the release cycle wins over the release
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        latched <= '0;
      else if (abnormal && qual_cnt == TMR_W'(QUALIFY_TICKS))
        latched <= latched | seen;                              // RULE13 RULE18
      else if (en_rise)
        latched <= '0;                                          // RULE19
    end

    assign kind_open[ch]    = latched[0];
    assign kind_short[ch]   = latched[1];
    assign kind_tr_open[ch] = latched[2];
    assign channel_fault_latched[ch] = |latched;

    // transistor short: hysteretic, never latched, never gates the channel
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        tr_short[ch] <= 1'b0;
      else if (s_high_s[ch])
        tr_short[ch] <= 1'b1;                                   // RULE15
      else if (s_low_s[ch])
        tr_short[ch] <= 1'b0;                                   // RULE15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indicator: registered one cycle behind the latches, so the gate is
  // already off when the first low phase starts
  ind_state_t ind;
  ind_state_t next_ind;

  always_comb
  begin
    if (ot_latched || (|tr_short))
      next_ind = IND_FULL;                                      // RULE12 RULE16
    else if (|kind_tr_open)
      next_ind = IND_Q3;
    else if (|kind_short)
      next_ind = IND_Q2;
    else if (|kind_open)
      next_ind = IND_Q1;
    else
      next_ind = IND_NONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ind <= IND_NONE;
    else
      ind <= next_ind;                                          // RULE10
  end

  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] low_len;

  always_ff @(posedge ref_clk)
  begin
    if (reset || ind == IND_NONE)
      per_cnt <= '0;
    else if (per_cnt == PER_W'(FAULT_PERIOD - 1))
      per_cnt <= '0;                                            // RULE11
    else
      per_cnt <= per_cnt + 1'b1;
  end

  always_comb
  begin
    case (ind)
      IND_Q1:   low_len = PER_W'(FAULT_QUARTER);                // RULE12
      IND_Q2:   low_len = PER_W'(2 * FAULT_QUARTER);            // RULE12
      IND_Q3:   low_len = PER_W'(3 * FAULT_QUARTER);            // RULE12
      default:  low_len = '0;
    endcase
  end

  // open drain: output data is always low, enable pulls the line
  assign fault_indicator_output = 1'b0;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      fault_indicator_oe <= 1'b0;
    else
      fault_indicator_oe <= (ind == IND_FULL) ||
                            ((ind != IND_NONE) && (per_cnt < low_len));  // RULE11 RULE12
  end

endmodule : led_channel_phase_fault_ctrl

// File: led_phase_fault_chk.sv
/*
  Port-level assertions for the gate sequencer and fault monitor.
  Assumes it is bound to the top module: one clock, synchronous reset.
*/
`timescale 1ns/100ps
module led_phase_fault_chk
(
  input wire logic                                    ref_clk,
  input wire logic                                    reset,
  input wire logic [led_phase_fault_pkg::NUM_CTRL-1:0] pwm_control_input,
  input wire logic                                    enable,
  input wire logic                                    overtemp_detect,
  input wire logic [led_phase_fault_pkg::NUM_CH-1:0]   gate_drive_output,
  input wire logic                                    regulator_output_enable,
  input wire logic [led_phase_fault_pkg::NUM_CH-1:0]   channel_fault_latched,
  input wire logic                                    fault_indicator_oe
);
  import led_phase_fault_pkg::*;
  logic [15:0] rp;
  logic [15:0] rc;
  logic [15:0] g0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  // saturating run lengths; wrapping would fake a short run
  always_ff @(posedge ref_clk)
  begin
    if (reset || !pwm_control_input[0]) rp <= 16'h0000;
    else if (rp != 16'hFFFF) rp <= rp + 16'h0001;
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset || !(pwm_control_input[0] && enable && regulator_output_enable) || channel_fault_latched[1])
      rc <= 16'h0000;
    else if (rc != 16'hFFFF) rc <= rc + 16'h0001;
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset || !gate_drive_output[0]) g0 <= 16'h0000;
    else if (g0 != 16'hFFFF) g0 <= g0 + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_on0;
    (pwm_control_input[0] && enable && regulator_output_enable)[*3];
  endsequence
  sequence s_hot;
    overtemp_detect[*3];
  endsequence
  a_ch0_at_once: assert property ($rose(pwm_control_input[0]) ##0 s_on0 |=> gate_drive_output[0])
    else $error("channel 0 gate late");
  a_ch1_unit_min: assert property ($rose(gate_drive_output[1]) |-> rp >= 16'h0200)
    else $error("channel 1 gate before one unit");
  a_ch1_unit_max: assert property (rc == 16'h02BC |-> gate_drive_output[1])
    else $error("channel 1 gate missing");
  a_enable_off_all: assert property ((!enable)[*3] |=> gate_drive_output == 8'h00)
    else $error("gate on while disabled");
  a_hot_reg_off: assert property (s_hot |=> !regulator_output_enable)
    else $error("regulator not shut off");
  a_hot_gates_off: assert property (!regulator_output_enable |=> gate_drive_output == 8'h00)
    else $error("gate on during overtemperature");
  a_hot_full_low: assert property ((!regulator_output_enable)[*4] |-> fault_indicator_oe)
    else $error("indicator not fully low");
  a_latch_iso: assert property (|channel_fault_latched |=>
      (gate_drive_output & $past(channel_fault_latched)) == 8'h00)
    else $error("faulty channel still driven");
  a_off_first: assert property ($rose(fault_indicator_oe) |-> (gate_drive_output & channel_fault_latched) == 8'h00)
    else $error("indicator before isolation");
  a_settle_qual: assert property ($rose(channel_fault_latched[0]) |-> g0 >= 16'h0410)
    else $error("fault latched too early");
endmodule : led_phase_fault_chk

// File: led_phase_fault_pkg.sv
/*
  Shared constants for the eight-channel gate sequencer and fault monitor:
  clock rates, derived tick counts, indicator timing and fault codes.
  Assumes a 40 MHz reference clock; all rates derive from it.
*/
package led_phase_fault_pkg;

  localparam int NUM_CH   = 8;
  localparam int NUM_CTRL = 4;

  // time bases
  localparam int REF_CLK_NS = 25;
  localparam int INT_CLK_NS = 3200;
  localparam int INT_DIV    = INT_CLK_NS / REF_CLK_NS;
  localparam int DIV_W      = $clog2(INT_DIV);

  // phase stagger, in internal clock ticks
  localparam int UNIT_TICKS = 4;
  localparam int MAX_UNITS  = 7;
  // one entry past the longest tap: channel k reads k whole units back
  localparam int HIST_LEN   = MAX_UNITS * UNIT_TICKS + 1;

  // detection timers: least times, rounded up to whole ticks
  localparam int SETTLE_NS     = 13000;
  localparam int QUALIFY_NS    = 13000;
  localparam int SETTLE_TICKS  = (SETTLE_NS + INT_CLK_NS - 1) / INT_CLK_NS;
  localparam int QUALIFY_TICKS = (QUALIFY_NS + INT_CLK_NS - 1) / INT_CLK_NS;
  localparam int TMR_W         = 4;

  // fault indicator toggle rate and low-time quarters
  localparam int FAULT_FREQ_HZ = 80000;
  localparam int FAULT_PERIOD  = 1000000000 / (FAULT_FREQ_HZ * REF_CLK_NS);
  localparam int FAULT_QUARTER = FAULT_PERIOD / 4;
  localparam int PER_W         = $clog2(FAULT_PERIOD);

  // feedback grouping mode pin encoding
  localparam logic [1:0] MODE_TWO   = 2'h0;
  localparam logic [1:0] MODE_FOUR  = 2'h1;
  localparam logic [1:0] MODE_EIGHT = 2'h2;

  // latched channel fault kinds, one-hot
  typedef enum logic [2:0] {
    KIND_STR_OPEN  = 3'h1,
    KIND_STR_SHORT = 3'h2,
    KIND_TR_OPEN   = 3'h4
  } fault_kind_t;

  // indicator low-time selection
  typedef enum logic [4:0] {
    IND_NONE = 5'h01,
    IND_Q1   = 5'h02,
    IND_Q2   = 5'h04,
    IND_Q3   = 5'h08,
    IND_FULL = 5'h10
  } ind_state_t;

endpackage : led_phase_fault_pkg

// File: testbench.sv
/*
  Self-checking bench for the gate sequencer and fault monitor.
  Assumes the host model drives control and enable; the bench drives
  mode, comparators, overtemperature and reset.
*/
`timescale 1ns/100ps
module testbench;
  import led_phase_fault_pkg::*;
  logic                ref_clk;
  logic                reset;
  logic [NUM_CTRL-1:0] pwm_control_input;
  logic                enable;
  logic [1:0]          feedback_mode;
  logic [NUM_CH-1:0]   drain_open_cmp;
  logic [NUM_CH-1:0]   drain_short_cmp;
  logic [NUM_CH-1:0]   source_open_cmp;
  logic [NUM_CH-1:0]   source_above_set;
  logic [NUM_CH-1:0]   source_below_release;
  logic                overtemp_detect;
  logic [NUM_CH-1:0]   gate_drive_output;
  logic                regulator_output_enable;
  logic [NUM_CH-1:0]   channel_fault_latched;
  logic                fault_indicator_oe;
  logic                short_ref_from_pin;
  logic                fault_indicator_output;
  int                  miscompares = 0;
  int                  n_checks = 0;
  led_channel_phase_fault_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .pwm_control_input(pwm_control_input),
    .enable(enable), .feedback_mode(feedback_mode), .drain_open_cmp(drain_open_cmp),
    .drain_short_cmp(drain_short_cmp), .source_open_cmp(source_open_cmp), .source_above_set(source_above_set),
    .source_below_release(source_below_release), .overtemp_detect(overtemp_detect),
    .gate_drive_output(gate_drive_output), .short_ref_from_pin(short_ref_from_pin),
    .regulator_output_enable(regulator_output_enable), .channel_fault_latched(channel_fault_latched),
    .fault_indicator_output(fault_indicator_output), .fault_indicator_oe(fault_indicator_oe));
  host_model host_u (.ref_clk(ref_clk), .pwm_control_input(pwm_control_input), .enable(enable));
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic check(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      miscompares++;
    end
  endtask : check
  // a wait that runs out ends the run at once
  task automatic bound(input bit ok, input string m);
    check(ok, m);
    if (!ok) results();
  endtask : bound
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_stagger();
    logic [1:0] md [5] = '{MODE_TWO, MODE_TWO, MODE_FOUR, MODE_FOUR, MODE_EIGHT};
    logic [3:0] cv [5] = '{4'hF, 4'h2, 4'h1, 4'h4, 4'h1};
    logic [7:0] em [5] = '{8'hFF, 8'h0C, 8'h73, 8'hCC, 8'hFF};
    int         first [8];
    for (int r = 0; r < 5; r++)
    begin
      host_u.drive(4'h0, 1'b1);
      @(posedge ref_clk);
      feedback_mode <= md[r];
      cyc(3800);
      check(gate_drive_output === 8'h00, "gates not idle");
      check(short_ref_from_pin === (md[r] == MODE_FOUR || md[r] == MODE_EIGHT), "threshold source");
      first = '{default: -1};
      host_u.drive(cv[r], 1'b1);
      for (int t = 1; t <= 3800; t++)
      begin
        cyc(1);
        for (int k = 0; k < 8; k++)
          if (gate_drive_output[k] === 1'b1 && first[k] < 0) first[k] = t;
      end
      for (int k = 0; k < 8; k++)
        if (em[r][k])
          check(first[k] >= k*512+3 && first[k] <= k*512+131, "stagger");
        else
          check(first[k] < 0, "wrong channel");
    end
    $display("test stagger done");
  endtask : t_stagger
  task automatic t_enable();
    host_u.drive(4'h1, 1'b0);
    cyc(2);
    check(gate_drive_output === 8'hFF, "gates dropped early");
    cyc(1);
    check(gate_drive_output === 8'h00, "gates not off together");
    cyc(200);
    host_u.drive(4'h1, 1'b1);
    cyc(3);
    check(gate_drive_output === 8'hFF, "gates not on together");
    $display("test enable done");
  endtask : t_enable
  task automatic t_faults();
    int h;
    int l;
    @(posedge ref_clk);
    feedback_mode <= MODE_TWO;
    for (int q = 1; q <= 3; q++)
    begin
      // bit 2 sits on a channel that is off and must be ignored
      @(posedge ref_clk);
      drain_open_cmp  <= (q == 1) ? 8'h05 : 8'h00;
      drain_short_cmp <= (q == 2) ? 8'h05 : 8'h00;
      source_open_cmp <= (q == 3) ? 8'h05 : 8'h00;
      for (h = 0; h < 3000 && channel_fault_latched === 8'h00; h++) cyc(1);
      bound(channel_fault_latched === 8'h01, "latch");
      for (h = 0; h < 600 && fault_indicator_oe !== 1'b1; h++) cyc(1);
      bound(fault_indicator_oe === 1'b1, "no indicator");
      for (h = 0; h < 600 && fault_indicator_oe === 1'b1; h++) cyc(1);
      for (l = 0; l < 600 && fault_indicator_oe === 1'b0; l++) cyc(1);
      check(h == q*125, "low time");
      check(h + l == 500, "period");
      check(fault_indicator_output === 1'b0, "indicator drive level");
      @(posedge ref_clk);
      drain_open_cmp  <= 8'h00;
      drain_short_cmp <= 8'h00;
      source_open_cmp <= 8'h00;
      cyc(600);
      check(channel_fault_latched === 8'h01, "latch lost");
      check(gate_drive_output === 8'h02, "not isolated");
      host_u.toggle_enable();
      cyc(6);
      check(channel_fault_latched === 8'h00, "latch kept");
    end
    $display("test faults done");
  endtask : t_faults
  task automatic t_tshort();
    int n = 0;
    @(posedge ref_clk);
    source_above_set     <= 8'h10;
    source_below_release <= 8'hEF;
    cyc(20);
    for (int i = 0; i < 600; i++)
    begin
      cyc(1);
      if (fault_indicator_oe === 1'b1) n++;
    end
    check(n == 600, "not fully low");
    check(channel_fault_latched === 8'h00 && gate_drive_output === 8'h03, "short latched");
    @(posedge ref_clk);
    source_above_set <= 8'h00;
    cyc(50);
    check(fault_indicator_oe === 1'b1, "released early");
    @(posedge ref_clk);
    source_below_release <= 8'hFF;
    for (n = 0; n < 600 && fault_indicator_oe !== 1'b0; n++) cyc(1);
    bound(fault_indicator_oe === 1'b0, "not released");
    $display("test transistor short done");
  endtask : t_tshort
  task automatic t_overtemp();
    @(posedge ref_clk);
    overtemp_detect <= 1'b1;
    cyc(10);
    @(posedge ref_clk);
    overtemp_detect <= 1'b0;
    cyc(20);
    check(regulator_output_enable === 1'b0 && gate_drive_output === 8'h00, "not shut down");
    check(fault_indicator_oe === 1'b1, "indicator not low");
    host_u.toggle_enable();
    cyc(6);
    check(regulator_output_enable === 1'b1, "regulator stuck off");
    $display("test overtemp done");
  endtask : t_overtemp
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    reset                = 1'b1;
    feedback_mode        = MODE_TWO;
    drain_open_cmp       = 8'h00;
    drain_short_cmp      = 8'h00;
    source_open_cmp      = 8'h00;
    source_above_set     = 8'h00;
    source_below_release = 8'hFF;
    overtemp_detect      = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(2);
    t_stagger();
    t_enable();
    t_faults();
    t_tshort();
    t_overtemp();
    results();
  end
endmodule : testbench

bind led_channel_phase_fault_ctrl led_phase_fault_chk chk_u (.ref_clk(ref_clk), .reset(reset),
  .pwm_control_input(pwm_control_input), .enable(enable), .overtemp_detect(overtemp_detect),
  .gate_drive_output(gate_drive_output), .regulator_output_enable(regulator_output_enable),
  .channel_fault_latched(channel_fault_latched), .fault_indicator_oe(fault_indicator_oe));
